// ===== hdl/rst_seq_pkg.sv
// Purpose: constants for the reset and initialization sequencer
// Assumes: 50 MHz system clock, Avalon-MM register access
// Notes: register word offsets are byte addresses
package rst_seq_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [5:0] ADDR_PORT_L_DATA = 6'h00;
  localparam logic [5:0] ADDR_PORT_L_CFG = 6'h04;
  localparam logic [5:0] ADDR_PORT_G_DATA = 6'h08;
  localparam logic [5:0] ADDR_PORT_G_CFG = 6'h0C;
  localparam logic [5:0] ADDR_PORT_D = 6'h10;
  localparam logic [5:0] ADDR_STACK_PTR = 6'h14;
  localparam logic [5:0] ADDR_PTR_B = 6'h18;
  localparam logic [5:0] ADDR_PTR_X = 6'h1C;
  localparam logic [5:0] ADDR_CAN_CTRL = 6'h20;
  localparam logic [5:0] ADDR_CAN_STATUS = 6'h24;
  localparam logic [5:0] ADDR_SEQ_STATUS = 6'h28;
  localparam logic [5:0] ADDR_SECURITY = 6'h2C;
  localparam logic [5:0] ADDR_PROG_READ = 6'h30;
  // ****************
  // Fields and resets
  // ****************
  localparam int CAN_CAN_TX0_DRIVE_ENABLE_BIT = 0;
  localparam int CAN_CAN_TX1_DRIVE_ENABLE_BIT = 1;
  localparam int TBE_BIT = 0;
  localparam int BUS_IDLE_BIT = 1;
  localparam logic [7:0] STACK_PTR_RESET = 8'h2F;
  localparam logic [3:0] PORT_D_RESET = 4'hF;
  localparam logic [7:0] CAN_STATUS_RESET = 8'h01;
  localparam logic [7:0] SEC_UNSECURED = 8'h00;
  localparam logic [7:0] SEC_SECURED = 8'hFF;
  localparam logic [7:0] SECURED_READ = 8'h00;
  // ****************
  // Timing
  // ****************
  localparam int CLK_MHZ = 50;
  localparam int INSTR_DIV = 10;
  localparam logic [3:0] INSTR_DIV_LAST = 4'(INSTR_DIV - 1);
  localparam int POR_CYCLES = 256;
  localparam logic [8:0] POR_LAST = 9'(POR_CYCLES - 1);
  localparam int IDLE_BITS = 11;
  localparam logic [3:0] IDLE_BITS_W = 4'(IDLE_BITS);
  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;
  typedef enum logic [2:0] {
    CAN_OFF = 3'b001,
    CAN_WAIT_IDLE = 3'b010,
    CAN_ACTIVE = 3'b100
  } can_state_t;
endpackage

// ===== hdl/reset_init_sequencer.sv
// Purpose: reset and power-on delay sequencer with reset-valued register set
// Assumes: i_can_bit_tick marks a CAN bit sample; i_can_rx high is recessive
// Notes: registers on Avalon-MM, one wait state per access
module reset_init_sequencer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ext_resetn,
  input wire logic i_por_detect,
  input wire logic i_secured,
  input wire logic [7:0] i_prog_data,
  input wire logic i_can_bit_tick,
  input wire logic i_can_rx,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_core_reset,
  output logic o_instr_tick,
  output logic [7:0] o_port_l_out,
  output logic [7:0] o_port_l_oe_n,
  output logic [7:0] o_port_g_out,
  output logic [7:0] o_port_g_oe_n,
  output logic [3:0] o_port_d,
  output logic [7:0] o_stack_pointer,
  output logic o_can_tx0_oe_n,
  output logic o_can_tx1_oe_n,
  output logic o_can_active
);
  import rst_seq_pkg::*;

  // ****************
  // State
  // ****************
  typedef struct packed {
    seq_state_t seq;
    can_state_t can;
    logic [3:0] div;
    logic tick;
    logic [8:0] por_cnt;
    logic [3:0] idle_cnt;
    logic [7:0] port_l_data;
    logic [7:0] port_l_cfg;
    logic [7:0] port_g_data;
    logic [7:0] port_g_cfg;
    logic [3:0] port_d;
    logic [14:0] program_counter;
    logic [7:0] processor_status_reg;
    logic [7:0] timer_serial_control_reg;
    logic [7:0] interrupt_control_reg;
    logic [7:0] wakeup_enable_reg;
    logic [7:0] wakeup_edge_select_reg;
    logic [7:0] wakeup_pending_reg;
    logic [7:0] stack_pointer;
    logic [7:0] comparator_control_reg;
    logic [7:0] pulse_width_control_reg;
    logic [7:0] can_prescaler_reg;
    logic [7:0] can_bit_timing_reg;
    logic [7:0] can_transmit_control_reg;
    logic [7:0] transmit_error_counter;
    logic [7:0] receive_error_counter;
    logic [7:0] can_rx_tx_status_reg;
    logic [1:0] tx_drive_en;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  // Pointers live outside the struct: warm reset must not touch them
  logic [7:0] ptr_b;
  logic [7:0] ptr_x;
  logic in_reset;
  logic req;

  assign in_reset = (st.seq != ST_RUN);
  assign req = (i_avs_read || i_avs_write) && !st.ack;

  // ****************
  // Next state
  // ****************
  always_comb begin
    next_st = st;
    next_st.ack = req;
    // Free-running divider; the instruction tick paces the power-on count and reset release, not reset entry
    next_st.tick = 1'b0;
    if (st.div == INSTR_DIV_LAST) begin
      next_st.div = 4'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 4'h1;
    end
    unique case (st.seq)
      ST_POR: begin
        if (st.tick) begin
          if (st.por_cnt == POR_LAST) begin
            next_st.seq = ST_RUN;
          end else begin
            next_st.por_cnt = st.por_cnt + 9'h001;
          end
        end
      end
      ST_HOLD: begin
        // Release aligned to the instruction clock
        if (st.tick) begin
          next_st.seq = ST_RUN;
        end
      end
      ST_RUN: begin
      end
    endcase
    if (i_por_detect) begin
      next_st.seq = ST_POR;
      next_st.por_cnt = 9'h000;
    end
    // External reset overrides and cancels the power-on count
    if (!i_ext_resetn) begin
      next_st.seq = ST_HOLD;
      next_st.por_cnt = 9'h000;
    end
    // CAN bus-idle gate
    unique case (st.can)
      CAN_OFF: begin
        if (st.tx_drive_en != 2'b00) begin
          next_st.can = CAN_WAIT_IDLE;
          next_st.idle_cnt = 4'h0;
        end
      end
      CAN_WAIT_IDLE: begin
        if (st.tx_drive_en == 2'b00) begin
          next_st.can = CAN_OFF;
        end else if (i_can_bit_tick) begin
          if (!i_can_rx) begin
            next_st.idle_cnt = 4'h0;
          end else if (st.idle_cnt == IDLE_BITS_W - 4'h1) begin
            next_st.can = CAN_ACTIVE;
          end else begin
            next_st.idle_cnt = st.idle_cnt + 4'h1;
          end
        end
      end
      CAN_ACTIVE: begin
        if (st.tx_drive_en == 2'b00) begin
          next_st.can = CAN_OFF;
        end
      end
    endcase
    // Register bus
    if (req && i_avs_read) begin
      next_st.rdata = 32'h0000_0000;
      unique case (i_avs_address)
        ADDR_PORT_L_DATA: next_st.rdata[7:0] = st.port_l_data;
        ADDR_PORT_L_CFG: next_st.rdata[7:0] = st.port_l_cfg;
        ADDR_PORT_G_DATA: next_st.rdata[7:0] = st.port_g_data;
        ADDR_PORT_G_CFG: next_st.rdata[7:0] = st.port_g_cfg;
        ADDR_PORT_D: next_st.rdata[3:0] = st.port_d;
        ADDR_STACK_PTR: next_st.rdata[7:0] = st.stack_pointer;
        ADDR_PTR_B: next_st.rdata[7:0] = ptr_b;
        ADDR_PTR_X: next_st.rdata[7:0] = ptr_x;
        ADDR_CAN_CTRL: next_st.rdata[1:0] = st.tx_drive_en;
        ADDR_CAN_STATUS: next_st.rdata[7:0] = st.can_rx_tx_status_reg;
        ADDR_SEQ_STATUS: next_st.rdata[3:0] = {st.can == CAN_ACTIVE,
                                               st.can == CAN_WAIT_IDLE,
                                               st.seq == ST_POR, in_reset};
        ADDR_SECURITY: next_st.rdata[7:0] = i_secured ? SEC_SECURED
                                                      : SEC_UNSECURED;
        ADDR_PROG_READ: next_st.rdata[7:0] = i_secured ? SECURED_READ
                                                       : i_prog_data;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (req && i_avs_write && i_avs_byteenable[0]) begin
      unique case (i_avs_address)
        ADDR_PORT_L_DATA: next_st.port_l_data = i_avs_writedata[7:0];
        ADDR_PORT_L_CFG: next_st.port_l_cfg = i_avs_writedata[7:0];
        ADDR_PORT_G_DATA: next_st.port_g_data = i_avs_writedata[7:0];
        ADDR_PORT_G_CFG: next_st.port_g_cfg = i_avs_writedata[7:0];
        ADDR_PORT_D: next_st.port_d = i_avs_writedata[3:0];
        ADDR_STACK_PTR: next_st.stack_pointer = i_avs_writedata[7:0];
        ADDR_CAN_CTRL: next_st.tx_drive_en = i_avs_writedata[1:0];
        default: begin
        end
      endcase
    end
    // Held in initial values for as long as reset lasts
    if (in_reset) begin
      next_st.port_l_data = 8'h00;
      next_st.port_l_cfg = 8'h00;
      next_st.port_g_data = 8'h00;
      next_st.port_g_cfg = 8'h00;
      next_st.port_d = PORT_D_RESET;
      next_st.program_counter = 15'h0000;
      next_st.processor_status_reg = 8'h00;
      next_st.timer_serial_control_reg = 8'h00;
      next_st.interrupt_control_reg = 8'h00;
      next_st.wakeup_enable_reg = 8'h00;
      next_st.wakeup_edge_select_reg = 8'h00;
      next_st.wakeup_pending_reg = 8'h00;
      next_st.stack_pointer = STACK_PTR_RESET;
      next_st.comparator_control_reg = 8'h00;
      next_st.pulse_width_control_reg = 8'h00;
      next_st.can_prescaler_reg = 8'h00;
      next_st.can_bit_timing_reg = 8'h00;
      next_st.can_transmit_control_reg = 8'h00;
      next_st.transmit_error_counter = 8'h00;
      next_st.receive_error_counter = 8'h00;
      next_st.can_rx_tx_status_reg = CAN_STATUS_RESET;
      next_st.tx_drive_en = 2'b00;
      next_st.can = CAN_OFF;
      next_st.idle_cnt = 4'h0;
    end
    next_st.can_rx_tx_status_reg[BUS_IDLE_BIT] = (next_st.can == CAN_ACTIVE);
  end

  // ****************
  // Registers
  // ****************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{seq: ST_POR, can: CAN_OFF, port_d: PORT_D_RESET,
              stack_pointer: STACK_PTR_RESET,
              can_rx_tx_status_reg: CAN_STATUS_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Pointers keep their value through warm reset; no power-up value
  always_ff @(posedge i_clk) begin
    if (req && i_avs_write && i_avs_byteenable[0] && !in_reset) begin
      if (i_avs_address == ADDR_PTR_B) begin
        ptr_b <= i_avs_writedata[7:0];
      end
      if (i_avs_address == ADDR_PTR_X) begin
        ptr_x <= i_avs_writedata[7:0];
      end
    end
  end

  // ****************
  // Outputs
  // ****************
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st.ack;
  assign o_avs_readdata = st.rdata;
  assign o_core_reset = in_reset;
  assign o_instr_tick = st.tick;
  assign o_port_l_out = st.port_l_data;
  assign o_port_l_oe_n = ~st.port_l_cfg;
  assign o_port_g_out = st.port_g_data;
  assign o_port_g_oe_n = ~st.port_g_cfg;
  assign o_port_d = st.port_d;
  assign o_stack_pointer = st.stack_pointer;
  assign o_can_tx0_oe_n = !st.tx_drive_en[CAN_CAN_TX0_DRIVE_ENABLE_BIT];
  assign o_can_tx1_oe_n = !st.tx_drive_en[CAN_CAN_TX1_DRIVE_ENABLE_BIT];
  // Gate on the enables too: the state machine leaves ACTIVE one clock after a disable
  assign o_can_active = (st.can == CAN_ACTIVE) && (st.tx_drive_en != 2'b00);
endmodule

// ===== tb/reset_init_sequencer_properties.sv
// Purpose: port-level properties of the reset sequencer
// Assumes: one clock domain, async active-low power reset
// Notes: bound to every instance of the sequencer
module reset_init_sequencer_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ext_resetn,
  input wire logic i_por_detect,
  input wire logic i_can_bit_tick,
  input wire logic i_can_rx,
  input wire logic o_core_reset,
  input wire logic o_instr_tick,
  input wire logic [7:0] o_port_l_oe_n,
  input wire logic [7:0] o_port_g_oe_n,
  input wire logic [3:0] o_port_d,
  input wire logic [7:0] o_stack_pointer,
  input wire logic o_can_tx0_oe_n,
  input wire logic o_can_tx1_oe_n,
  input wire logic o_can_active
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_held; o_core_reset && $past(o_core_reset); endsequence
  sequence s_tick_gap; !o_instr_tick[*8] ##1 !o_instr_tick ##1 o_instr_tick; endsequence
  property p_ports_float; s_held |-> o_port_l_oe_n == 8'hFF && o_port_g_oe_n == 8'hFF; endproperty
  property p_port_d_high; s_held |-> o_port_d == 4'hF; endproperty
  property p_stack_init; s_held |-> o_stack_pointer == 8'h2F; endproperty
  property p_can_gate; o_can_active |-> !(o_can_tx0_oe_n && o_can_tx1_oe_n); endproperty
  property p_idle_seen; $rose(o_can_active) |-> $past(i_can_bit_tick && i_can_rx); endproperty
  property p_por_hold; i_por_detect && i_ext_resetn |=> o_core_reset[*8]; endproperty
  property p_ext_wins; $fell(i_ext_resetn) |-> ##[1:3] o_core_reset[*2]; endproperty
  property p_ext_release; $rose(i_ext_resetn) && !i_por_detect |-> ##[1:14] !o_core_reset;
  endproperty
  property p_tick_period; o_instr_tick |=> s_tick_gap; endproperty
  property p_release_tick; $fell(o_core_reset) |-> o_instr_tick || $past(o_instr_tick); endproperty
  a_ports_float: assert property (p_ports_float) else $error("ports driven in reset");
  a_port_d_high: assert property (p_port_d_high) else $error("port d low in reset");
  a_stack_init: assert property (p_stack_init) else $error("stack pointer wrong");
  a_can_gate: assert property (p_can_gate) else $error("can active while disabled");
  a_idle_seen: assert property (p_idle_seen) else $error("can active without idle");
  a_por_hold: assert property (p_por_hold) else $error("power-on hold too short");
  a_ext_wins: assert property (p_ext_wins) else $error("external reset ignored");
  a_ext_release: assert property (p_ext_release) else $error("reset release late");
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
  a_release_tick: assert property (p_release_tick) else $error("release off tick");
endmodule
bind reset_init_sequencer reset_init_sequencer_checker u_chk (.i_clk, .i_resetn, .i_ext_resetn,
  .i_por_detect, .i_can_bit_tick, .i_can_rx, .o_core_reset, .o_instr_tick, .o_port_l_oe_n,
  .o_port_g_oe_n, .o_port_d, .o_stack_pointer, .o_can_tx0_oe_n, .o_can_tx1_oe_n, .o_can_active);

// ===== tb/can_bus_model.sv
// Purpose: CAN bus bit source for the sequencer bench
// Assumes: bits arrive as one-cycle sample ticks
// Notes: gap sets how slowly bits come
module can_bus_model (
  input wire logic i_clk,
  output logic o_bit_tick,
  output logic o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_bit_tick = 1'b0;
    o_rx = 1'b1;
  end
  task automatic send(input int n, input logic lvl, input int gap);
    repeat (n) begin
      @(posedge i_clk);
      o_bit_tick <= 1'b1;
      o_rx <= lvl;
      @(posedge i_clk);
      o_bit_tick <= 1'b0;
      repeat (gap) @(posedge i_clk);
    end
    // Undriven bus floats recessive
    o_rx <= 1'b1;
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the reset sequencer
// Assumes: bus master waits for waitrequest low, however long it takes
// Notes: expectations come from a map model
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_seq_pkg::*;
  logic i_clk, i_resetn, i_ext_resetn, i_por_detect, i_secured, i_avs_read, i_avs_write;
  logic i_can_bit_tick, i_can_rx, o_avs_waitrequest, o_core_reset, o_instr_tick;
  logic o_can_tx0_oe_n, o_can_tx1_oe_n, o_can_active;
  logic [7:0] i_prog_data, o_port_l_out, o_port_l_oe_n, o_port_g_out, o_port_g_oe_n;
  logic [7:0] o_stack_pointer;
  logic [5:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable, o_port_d;
  int failures, check_count, cyc, n;
  int mdl[int];
  reset_init_sequencer uut (.i_clk, .i_resetn, .i_ext_resetn, .i_por_detect, .i_secured,
    .i_prog_data, .i_can_bit_tick, .i_can_rx, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_core_reset,
    .o_instr_tick, .o_port_l_out, .o_port_l_oe_n, .o_port_g_out, .o_port_g_oe_n, .o_port_d,
    .o_stack_pointer, .o_can_tx0_oe_n, .o_can_tx1_oe_n, .o_can_active);
  can_bus_model can (.i_clk(i_clk), .o_bit_tick(i_can_bit_tick), .o_rx(i_can_rx));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 12000) begin
      failures++;
      stop_test();
    end
  end
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_avs_address, i_avs_write, i_avs_read, i_avs_writedata} <= {a, wr, !wr, 24'h0, d};
    // Sampled at the rising edge, before that edge's updates land
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    {i_avs_write, i_avs_read} <= 2'b00;
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 8'h00);
    if (mdl.exists(a)) `CHK(q, 32'(mdl[a]), "read mismatch")
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    mdl[a] = (a == ADDR_PORT_D) ? int'(d[3:0]) : int'(d);
  endtask
  task automatic model_reset(input bit power);
    mdl[ADDR_PORT_L_DATA] = 0;
    mdl[ADDR_PORT_L_CFG] = 0;
    mdl[ADDR_PORT_G_DATA] = 0;
    mdl[ADDR_PORT_G_CFG] = 0;
    mdl[ADDR_PORT_D] = PORT_D_RESET;
    mdl[ADDR_STACK_PTR] = STACK_PTR_RESET;
    mdl[ADDR_CAN_STATUS] = CAN_STATUS_RESET;
    if (power) mdl.delete(ADDR_PTR_B);
    if (power) mdl.delete(ADDR_PTR_X);
  endtask
  task automatic wait_run();
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_core_reset !== 1'b0 && n < 3000);
  endtask
  task automatic ext_reset();
    @(posedge i_clk);
    i_ext_resetn <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_ext_resetn <= 1'b1;
    model_reset(1'b0);
    wait_run();
    `CHK(n <= INSTR_DIV + 4, 1'b1, "external release late")
  endtask
  task automatic rd_all();
    foreach (mdl[a]) rd(6'(a));
  endtask
  initial begin
    {i_resetn, i_por_detect, i_secured, i_avs_read, i_avs_write} = 5'b0;
    {i_ext_resetn, i_avs_byteenable, i_prog_data, i_avs_address, i_avs_writedata} = '1;
    void'($urandom(36));
    repeat (3) @(posedge i_clk);
    `CHK({o_port_d, o_port_l_oe_n, o_port_g_oe_n}, 20'hFFFFF, "ports in reset")
    `CHK(o_stack_pointer, STACK_PTR_RESET, "stack pointer in reset")
    i_resetn <= 1'b1;
    model_reset(1'b1);
    wait_run();
    `CHK(n >= POR_CYCLES * INSTR_DIV && n <= POR_CYCLES * INSTR_DIV + 12, 1'b1, "delay")
    rd_all();
    for (int i = 0; i < 8; i++) wr(6'(4 * i), 8'($urandom));
    `CHK(o_port_l_oe_n, ~8'(mdl[ADDR_PORT_L_CFG]), "port l drive")
    `CHK(o_port_g_out, 8'(mdl[ADDR_PORT_G_DATA]), "port g data")
    `CHK(o_port_l_out, 8'(mdl[ADDR_PORT_L_DATA]), "port l data")
    rd_all();
    $display("power-up and register test done");
    ext_reset();
    `CHK({o_port_l_oe_n, o_port_g_oe_n, o_port_d}, 20'hFFFFF, "ports after reset")
    rd_all();
    @(posedge i_clk) i_por_detect <= 1'b1;
    @(posedge i_clk) i_por_detect <= 1'b0;
    repeat (100) @(posedge i_clk);
    `CHK(o_core_reset, 1'b1, "power-on hold")
    ext_reset();
    $display("reset priority test done");
    can.send(12, 1'b1, 0);
    `CHK({o_can_active, o_can_tx0_oe_n, o_can_tx1_oe_n}, 3'b011, "can before enable")
    wr(ADDR_CAN_CTRL, 8'h02);
    `CHK({o_can_tx0_oe_n, o_can_tx1_oe_n}, 2'b10, "tx1 drive")
    can.send(10, 1'b1, 3);
    can.send(1, 1'b0, 1);
    can.send(IDLE_BITS - 1, 1'b1, 2);
    `CHK(o_can_active, 1'b0, "active too early")
    can.send(1, 1'b1, 2);
    `CHK(o_can_active, 1'b1, "active after idle")
    wr(ADDR_CAN_CTRL, 8'h00);
    @(negedge i_clk);
    `CHK({o_can_active, o_can_tx0_oe_n, o_can_tx1_oe_n}, 3'b011, "can disabled")
    $display("can test done");
    for (int s = 0; s < 2; s++) begin
      // Secured only after the unsecured verify pass below
      @(posedge i_clk) {i_secured, i_prog_data} <= {s[0], 8'($urandom)};
      @(posedge i_clk);
      mdl[ADDR_SECURITY] = s ? SEC_SECURED : SEC_UNSECURED;
      mdl[ADDR_PROG_READ] = s ? SECURED_READ : i_prog_data;
      rd(ADDR_SECURITY);
      rd(ADDR_PROG_READ);
    end
    mdl[6'h3C] = 0;
    rd(6'h3C);
    $display("security test done");
    stop_test();
  end
endmodule
